// *** chgctl_host_model.sv ***
// Host controller model driving the AXI4-Lite register bus
`timescale 1ns/1ps
module chgctl_host_model (
  input  wire logic        clock,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Answer-accept delay; nonzero plays a slow host
  int lag = 0;
  // Idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
  end
  // Released payload is inverted so stale values cannot pass
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready)
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid && s_axi_bready)
        break;
      if (n >= lag)
        s_axi_bready <= 1'b1;
      n++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read with the same hold-until-answer discipline
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid && s_axi_rready)
        break;
      if (n >= lag)
        s_axi_rready <= 1'b1;
      n++;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// *** chgctl_pkg.sv ***
// Shared constants and types for the charger cycle and comparator control
package chgctl_pkg;

  // ----------------------------------------------------------------
  // Clock and deglitch timing
  // ----------------------------------------------------------------
  localparam int CLK_NS  = 10;
  localparam int DEG0_NS = 100;
  localparam int DEG1_NS = 1000;
  localparam int DEG2_NS = 5000;
  localparam int DEG3_NS = 20000;
  localparam logic [11:0] DEG0_CYC = 12'((DEG0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] DEG1_CYC = 12'((DEG1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] DEG2_CYC = 12'((DEG2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] DEG3_CYC = 12'((DEG3_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CONFIG = 8'h00;
  localparam logic [7:0]  OFS_CHARGE = 8'h04;
  localparam logic [7:0]  OFS_TERM   = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0c;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0002;
  localparam logic [31:0] CHARGE_RST = 32'h0000_0000;
  localparam logic [31:0] TERM_RST   = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // CONFIG bit positions
  localparam int B_EXT     = 0;
  localparam int B_LP      = 1;
  localparam int B_LDO_LP  = 2;
  localparam int B_CMP_SEL = 3;
  localparam int B_LATCH   = 4;
  localparam int B_POL     = 5;
  localparam int B_DEG     = 6;
  localparam int B_FRC     = 8;
  localparam int B_ADC     = 9;
  localparam int B_LP_CMP  = 10;
  localparam int B_AUTO    = 11;
  localparam int B_HOLD    = 12;
  // STATUS bit positions
  localparam int B_FRC_F   = 3;
  localparam int B_OV_F    = 4;
  localparam int B_CMP_N   = 5;

  // Charge phase codes
  localparam logic [2:0] PH_IDLE    = 3'h0;
  localparam logic [2:0] PH_TRICKLE = 3'h1;
  localparam logic [2:0] PH_PRE     = 3'h2;
  localparam logic [2:0] PH_CC      = 3'h3;
  localparam logic [2:0] PH_CV      = 3'h4;
  localparam logic [2:0] PH_DONE    = 3'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_CHARGING, ST_DONE} chgctl_state_t;

  // Analog comparator and converter status inputs, synchronous to the clock
  typedef struct packed {
    logic vbus_gt_6v;
    logic vsys_gt_6v;
    logic vbus_higher;
    logic ext_ov;
    logic cmp_pin_high;
    logic conv_running;
    logic adapter_present;
    logic start_cmd;
    logic ichg_below_term;
    logic vbat_below_rechg;
    logic dpm_active;
    logic vbat_below_short;
    logic vbat_below_vsysmin;
    logic cv_loop;
    logic prot_fault;
    logic timer_fault;
  } chgctl_sense_t;

  // Controls to the analog and converter blocks
  typedef struct packed {
    logic       ldo_src_sys;
    logic       ldo_target_low;
    logic       ldo_on;
    logic       ldo_full_cap;
    logic       conv_enable;
    logic       cmp_enable;
    logic       cmp_adc_enable;
    logic       cmp_out_n;
    logic       charge_enable;
    logic [7:0] charge_current;
    logic [7:0] charge_voltage;
    logic [7:0] term_current;
    logic [3:0] recharge_offset;
  } chgctl_ctrl_t;

endpackage

// *** chgctl_tb_top.sv ***
// Self-checking bench for charger cycle and comparator control
`timescale 1ns/1ps
module chgctl_tb_top;
  import chgctl_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  chgctl_sense_t sense = '0;
  chgctl_ctrl_t  ctrl;
  logic          source_good_out;
  logic [7:0]    s_axi_awaddr, s_axi_araddr, cur;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic          s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic          s_axi_rready;
  logic [2:0]    v;
  logic [11:0]   t [4] = '{DEG0_CYC, DEG1_CYC, DEG2_CYC, DEG3_CYC};
  integer        seed;
  int            n_mismatch = 0;
  int            checks = 0;
  int            cyc = 0;
  chgctl_top DUT (
    .clock, .rst, .sense, .ctrl, .source_good_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  chgctl_host_model host (
    .clock,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // 100 MHz clock
  always #5 clock = ~clock;
  // Hang guard, well above the longest deglitch sweep
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Expected bias source: 1 picks the system rail
  function automatic logic src_exp(input logic [2:0] s);
    if (s[2] && s[1])
      return s[0];
    if (!s[2] && !s[1])
      return !s[0];
    return s[1];
  endfunction
  function automatic logic [31:0] rsp(input logic [7:0] a);
    return (a > OFS_STATUS) ? RESP_SLV : RESP_OKAY;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.write(a, d, r);
    chk(r, rsp(a));
    tk(3);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.read(a, d, r);
    chk(d & m, e);
    chk(r, rsp(a));
  endtask
  // Phase code and charge enable must agree
  task automatic ph(input logic [2:0] p);
    rc(OFS_STATUS, 32'h7, p);
    chk(ctrl.charge_enable, p != PH_IDLE && p != PH_DONE);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    seed = 32'h580c;
    tk(12);
    rst <= 1'b0;
    tk(1);
    rc(OFS_CONFIG, 32'hffffffff, CONFIG_RST);
    rc(OFS_CHARGE, 32'hffffffff, CHARGE_RST);
    rc(OFS_TERM, 32'hffffffff, TERM_RST);
    rc(8'h10, 32'hffffffff, 32'h0);
    wr(8'h14, 32'h1);
    host.lag = 3;
    wr(OFS_TERM, 32'h0a05);
    chk({ctrl.recharge_offset, ctrl.term_current}, 12'ha05);
    host.lag = 0;
    note("registers");
    // Every rail combination first, then random ones
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? 3'(i) : 3'($random(seed));
      {sense.vbus_gt_6v, sense.vsys_gt_6v, sense.vbus_higher} <= v;
      tk(3);
      chk(ctrl.ldo_src_sys, src_exp(v));
    end
    wr(OFS_CONFIG, 32'h1);
    chk(ctrl.ldo_target_low, 1'b1);
    wr(OFS_CONFIG, 32'h4);
    chk({ctrl.ldo_target_low, ctrl.ldo_on, ctrl.ldo_full_cap}, 3'h3);
    wr(OFS_CONFIG, 32'h2);
    chk({ctrl.ldo_on, ctrl.cmp_enable}, 2'b00);
    wr(OFS_CONFIG, 32'h406);
    chk({ctrl.ldo_on, ctrl.ldo_full_cap, ctrl.cmp_enable}, 3'h5);
    sense.start_cmd <= 1'b1;
    tk(3);
    chk(ctrl.ldo_full_cap, 1'b1);
    sense.start_cmd <= 1'b0;
    wr(OFS_CONFIG, 32'h208);
    chk(ctrl.cmp_adc_enable, 1'b1);
    sense.ext_ov <= 1'b1;
    tk(3);
    chk({ctrl.conv_enable, source_good_out}, 2'b00);
    rc(OFS_STATUS, 32'h10, 32'h10);
    sense.ext_ov <= 1'b0;
    wr(OFS_STATUS, 32'h10);
    rc(OFS_STATUS, 32'h10, 32'h0);
    note("bias");
    sense.adapter_present <= 1'b1;
    sense.conv_running <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CONFIG, 32'h20 | (k << 6));
      sense.cmp_pin_high <= 1'b1;
      tk(int'(t[k]) - 4);
      chk(ctrl.cmp_out_n, 1'b1);
      tk(8);
      chk(ctrl.cmp_out_n, 1'b0);
      sense.cmp_pin_high <= 1'b0;
      tk(int'(t[k]) + 4);
      chk(ctrl.cmp_out_n, 1'b1);
    end
    wr(OFS_CONFIG, 32'h0);
    tk(20);
    chk(ctrl.cmp_out_n, 1'b0);
    wr(OFS_CONFIG, 32'h120);
    tk(20);
    chk({ctrl.cmp_out_n, ctrl.conv_enable, source_good_out}, 3'h7);
    sense.cmp_pin_high <= 1'b1;
    tk(20);
    chk({ctrl.cmp_out_n, ctrl.conv_enable, source_good_out}, 3'h0);
    rc(OFS_STATUS, 32'h28, 32'h08);
    sense.adapter_present <= 1'b0;
    tk(5);
    rc(OFS_STATUS, 32'h08, 32'h08);
    sense.adapter_present <= 1'b1;
    sense.cmp_pin_high <= 1'b0;
    tk(20);
    rc(OFS_STATUS, 32'h28, 32'h20);
    wr(OFS_CONFIG, 32'h130);
    sense.cmp_pin_high <= 1'b1;
    tk(20);
    sense.cmp_pin_high <= 1'b0;
    tk(20);
    chk(ctrl.cmp_out_n, 1'b0);
    // Host clears the latch by toggling its enable
    wr(OFS_CONFIG, 32'h120);
    wr(OFS_CONFIG, 32'h130);
    chk(ctrl.cmp_out_n, 1'b1);
    note("comparator");
    wr(OFS_CONFIG, 32'h800);
    ph(PH_IDLE);
    // Kept below 0x80 so that its inverse is never a zero current
    cur = {1'b0, 7'($random(seed))} | 8'h01;
    wr(OFS_CHARGE, {16'h0, 8'h80, cur});
    chk({ctrl.charge_voltage, ctrl.charge_current}, {8'h80, cur});
    ph(PH_CC);
    sense.vbat_below_short <= 1'b1;
    tk(3);
    ph(PH_TRICKLE);
    sense.vbat_below_short <= 1'b0;
    sense.vbat_below_vsysmin <= 1'b1;
    tk(3);
    ph(PH_PRE);
    sense.vbat_below_vsysmin <= 1'b0;
    sense.cv_loop <= 1'b1;
    wr(OFS_CHARGE, {16'h0, 8'h7f, ~cur});
    chk({ctrl.charge_voltage, ctrl.charge_current}, {8'h7f, ~cur});
    ph(PH_CV);
    {sense.ichg_below_term, sense.dpm_active} <= 2'b11;
    tk(3);
    ph(PH_CV);
    sense.dpm_active <= 1'b0;
    tk(3);
    ph(PH_DONE);
    {sense.prot_fault, sense.vbat_below_rechg} <= 2'b11;
    tk(3);
    ph(PH_DONE);
    sense.prot_fault <= 1'b0;
    tk(3);
    ph(PH_CV);
    sense.vbat_below_rechg <= 1'b0;
    tk(3);
    ph(PH_DONE);
    sense.ichg_below_term <= 1'b0;
    wr(OFS_CONFIG, 32'h1800);
    ph(PH_DONE);
    wr(OFS_CONFIG, 32'h800);
    ph(PH_CV);
    // Terminate again, then restart by current going from zero to set
    sense.ichg_below_term <= 1'b1;
    tk(3);
    ph(PH_DONE);
    sense.ichg_below_term <= 1'b0;
    wr(OFS_CHARGE, {16'h0, 8'h7f, 8'h00});
    ph(PH_DONE);
    wr(OFS_CHARGE, {16'h0, 8'h7f, cur});
    ph(PH_CV);
    // Safety-timer fault and a stopped converter both end the cycle
    sense.timer_fault <= 1'b1;
    tk(3);
    ph(PH_IDLE);
    {sense.timer_fault, sense.conv_running} <= 2'b01;
    tk(3);
    ph(PH_CV);
    sense.conv_running <= 1'b0;
    tk(3);
    ph(PH_IDLE);
    note("charge");
    report_and_stop();
  end
endmodule

// *** chgctl_top.sv ***
// Charger bias regulator, comparator and autonomous charge cycle control
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module chgctl_top
  import chgctl_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire chgctl_pkg::chgctl_sense_t sense,
  output chgctl_pkg::chgctl_ctrl_t  ctrl,
  output logic                      source_good_out,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import chgctl_pkg::*;

  logic [31:0]   cfg;
  logic [31:0]   chg;
  logic [31:0]   term;
  logic          ov_fault;
  logic          frc_fault;
  logic [2:0]    phase;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          aw_got;
  logic          w_got;
  logic          do_write;
  logic [31:0]   status_rd;
  logic [11:0]   deg_cnt;
  logic [11:0]   deg_len;
  logic          trip_deg;
  logic          latched;
  logic          latch_en_q;
  logic          adapter_q;
  logic          hold_q;
  logic          cur_zero_q;
  logic          cmp_en;
  logic          trip_now;
  logic          cmp_active;
  logic          adapter_fall;
  logic          start_ok;
  chgctl_state_t state;
  chgctl_state_t next_state;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  // Merge byte lanes of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign do_write = aw_got && w_got && !s_axi_bvalid;

  // Address and data are taken in either order, one write at a time
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[7:2] <= OFS_STATUS[7:2]) ?
                        RESP_OKAY : RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable settings; new charge settings take effect at once
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg  <= CONFIG_RST;
      chg  <= CHARGE_RST;
      term <= TERM_RST;
    end else if (do_write) begin
      unique case (awaddr_q[7:2])
        OFS_CONFIG[7:2]: cfg  <= merge(cfg, wdata_q, wstrb_q) & 32'h1fff;
        OFS_CHARGE[7:2]: chg  <= merge(chg, wdata_q, wstrb_q) & 32'hffff;
        OFS_TERM[7:2]:   term <= merge(term, wdata_q, wstrb_q) & 32'h0fff;
        default: ;
      endcase
    end
  end

  assign status_rd = {26'h0, ctrl.cmp_out_n, ov_fault, frc_fault, phase};

  // Reads answer one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        OFS_CONFIG[7:2]: s_axi_rdata <= cfg;
        OFS_CHARGE[7:2]: s_axi_rdata <= chg;
        OFS_TERM[7:2]:   s_axi_rdata <= term;
        OFS_STATUS[7:2]: s_axi_rdata <= status_rd;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLV;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Independent comparator
  // ----------------------------------------------------------------
  assign adapter_fall = adapter_q && !sense.adapter_present;
  assign cmp_en = !cfg[B_CMP_SEL] &&
                  (!(cfg[B_LP] && !sense.adapter_present) || cfg[B_LP_CMP]);
  // polarity picks which pin level trips
  assign trip_now   = cmp_en && (sense.cmp_pin_high == cfg[B_POL]);
  assign cmp_active = trip_deg || latched;

  always_comb begin
    unique case (cfg[B_DEG +: 2])
      2'h0: deg_len = DEG0_CYC;
      2'h1: deg_len = DEG1_CYC;
      2'h2: deg_len = DEG2_CYC;
      2'h3: deg_len = DEG3_CYC;
    endcase
  end

  // A change must persist for the whole deglitch length to pass
  always_ff @(posedge clock) begin
    if (rst) begin
      deg_cnt  <= 12'h000;
      trip_deg <= 1'b0;
    end else if (trip_now == trip_deg) begin
      deg_cnt <= 12'h000;
    end else if (deg_cnt >= deg_len - 12'h001) begin
      deg_cnt  <= 12'h000;
      trip_deg <= trip_now;
    end else begin
      deg_cnt <= deg_cnt + 12'h001;
    end
  end

  // Latch: a fresh trip wins over the release toggle
  always_ff @(posedge clock) begin
    if (rst) begin
      latched    <= 1'b0;
      latch_en_q <= 1'b0;
    end else begin
      latch_en_q <= cfg[B_LATCH];
      if (cfg[B_LATCH] && trip_deg) begin
        latched <= 1'b1;
      end else if (cfg[B_LATCH] != latch_en_q) begin
        latched <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Faults
  // ----------------------------------------------------------------
  // Over-voltage is sticky until software writes one to clear it;
  // a live over-voltage re-sets it in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      ov_fault <= 1'b0;
    end else if (sense.ext_ov) begin
      ov_fault <= 1'b1;
    end else if (do_write && awaddr_q[7:2] == OFS_STATUS[7:2] &&
                 wstrb_q[0] && wdata_q[B_OV_F]) begin
      ov_fault <= 1'b0;
    end
  end

  // Forced shutdown tracks the comparator; one clear on adapter removal
  always_ff @(posedge clock) begin
    if (rst) begin
      frc_fault <= 1'b0;
      adapter_q <= 1'b0;
    end else begin
      adapter_q <= sense.adapter_present;
      if (adapter_fall) begin
        frc_fault <= 1'b0;
      end else begin
        frc_fault <= cfg[B_FRC] && cmp_active;
      end
    end
  end

  // ----------------------------------------------------------------
  // Autonomous charge cycle
  // ----------------------------------------------------------------
  // start conditions
  assign start_ok = sense.conv_running && cfg[B_AUTO] &&
                    chg[7:0] != 8'h00 && !cfg[B_HOLD] &&
                    !sense.prot_fault && !frc_fault &&
                    !sense.timer_fault;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_CHARGING;
        end
      end
      ST_CHARGING: begin
        if (!start_ok) begin
          next_state = ST_IDLE;
        end else if (sense.ichg_below_term && !sense.vbat_below_rechg &&
                     !sense.dpm_active) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!cfg[B_AUTO] || sense.timer_fault) begin
          next_state = ST_IDLE;
        end else if (start_ok && (sense.vbat_below_rechg ||
                     (hold_q && !cfg[B_HOLD]) || cur_zero_q)) begin
          next_state = ST_CHARGING;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= ST_IDLE;
      hold_q     <= 1'b0;
      cur_zero_q <= 1'b1;
    end else begin
      state      <= next_state;
      hold_q     <= cfg[B_HOLD];
      cur_zero_q <= chg[7:0] == 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= PH_IDLE;
    end else if (state == ST_DONE) begin
      phase <= PH_DONE;
    end else if (state != ST_CHARGING) begin
      phase <= PH_IDLE;
    end else if (sense.vbat_below_short) begin
      phase <= PH_TRICKLE;
    end else if (sense.vbat_below_vsysmin) begin
      phase <= PH_PRE;
    end else begin
      phase <= sense.cv_loop ? PH_CV : PH_CC;
    end
  end

  // ----------------------------------------------------------------
  // Output controls, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl            <= '0;
      ctrl.cmp_out_n  <= 1'b1;
      source_good_out <= 1'b0;
    end else begin
      if (sense.vbus_gt_6v == sense.vsys_gt_6v) begin
        ctrl.ldo_src_sys <= sense.vbus_gt_6v ? sense.vbus_higher
                                             : !sense.vbus_higher;
      end else begin
        ctrl.ldo_src_sys <= sense.vsys_gt_6v;
      end
      ctrl.ldo_target_low <= cfg[B_EXT];
      ctrl.ldo_on       <= !cfg[B_LP] || cfg[B_LDO_LP] || sense.start_cmd;
      ctrl.ldo_full_cap <= !cfg[B_LP] || sense.start_cmd;
      // stop switching and drop source good on faults
      ctrl.conv_enable <= !(sense.ext_ov || ov_fault ||
                            (cfg[B_FRC] && cmp_active));
      source_good_out  <= sense.adapter_present && !sense.ext_ov &&
                          !ov_fault && !(cfg[B_FRC] && cmp_active);
      ctrl.cmp_enable     <= cmp_en;
      // converter channel independent of pin function
      ctrl.cmp_adc_enable <= cfg[B_ADC];
      ctrl.cmp_out_n      <= !cmp_active;
      ctrl.charge_enable  <= state == ST_CHARGING;
      ctrl.charge_current <= chg[7:0];
      ctrl.charge_voltage <= chg[15:8];
      ctrl.term_current   <= term[7:0];
      ctrl.recharge_offset <= term[11:8];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  AST_LDO_SRC: assert property (
    sense.vbus_gt_6v && sense.vsys_gt_6v
    |=> ctrl.ldo_src_sys == $past(sense.vbus_higher))
    else $error("bias source not the lower rail");
  AST_LDO_LP: assert property (
    cfg[B_LP] && !cfg[B_LDO_LP] && !sense.start_cmd |=> !ctrl.ldo_on)
    else $error("regulator on in low power");
  AST_LDO_PERF: assert property (
    !cfg[B_LP] |=> ctrl.ldo_on && ctrl.ldo_full_cap)
    else $error("regulator not full in performance mode");
  AST_OV: assert property (
    sense.ext_ov |=> ov_fault && !ctrl.conv_enable && !source_good_out)
    else $error("over-voltage not handled");
  AST_LATCH_HOLD: assert property (
    latched && cfg[B_LATCH] == latch_en_q |=> latched)
    else $error("latched output dropped");
  AST_LATCH_CLR: assert property (
    cfg[B_LATCH] != latch_en_q && !trip_deg |=> !latched)
    else $error("latch not released on toggle");
  AST_FRC: assert property (
    cfg[B_FRC] && cmp_active && !adapter_fall
    |=> frc_fault ##0 !ctrl.conv_enable)
    else $error("forced shutdown missing");
  AST_FRC_REL: assert property (
    !cmp_active |=> !frc_fault)
    else $error("forced shutdown stuck");
  AST_REMOVE: assert property (
    adapter_fall |=> !frc_fault)
    else $error("no clear on adapter removal");
  AST_START: assert property (
    state == ST_IDLE && !start_ok |=> state != ST_CHARGING)
    else $error("charge started without conditions");
  AST_TERM: assert property (
    state == ST_CHARGING && start_ok && sense.dpm_active
    |=> state != ST_DONE)
    else $error("terminated during power limiting");
  AST_PHASE: assert property (
    state == ST_DONE |=> phase == PH_DONE)
    else $error("done code missing");

  COV_DONE:    cover property (state == ST_CHARGING ##1 state == ST_DONE);
  COV_RECHG:   cover property (state == ST_DONE ##1 state == ST_CHARGING);
  COV_FRC:     cover property (frc_fault ##1 !frc_fault);
  COV_LATCHED: cover property (latched && !trip_deg);

endmodule
